/* File: rtl/latch_ack_pkg.sv */
// latch_ack_pkg: sizes, relay states and timing constants for the latch acknowledge logic
// assumes a single 10 MHz system clock shared by every user of the package
package latch_ack_pkg;
  localparam int unsigned NUM_LAMPS = 8;      // indicator lamps per instance
  localparam int unsigned NUM_RELAYS = 8;     // binary output relays
  localparam int unsigned NUM_SCADA = 8;      // telecontrol signals
  localparam int unsigned NUM_SWGR = 2;       // switchgear instances
  localparam int unsigned CLK_HZ = 10_000_000; // system clock rate
  localparam int unsigned OFF_DELAY_US = 100;  // relay switch-off delay, plain default
  localparam int unsigned OFF_DELAY_CYC = (OFF_DELAY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                          OFF_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W = 16;          // width of off-delay counters
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000; // idle counter value
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;  // counter decrement step
  // per-relay release state
  typedef enum logic [2:0] {
    RLY_IDLE = 3'b001,
    RLY_HELD = 3'b010,
    RLY_WAIT = 3'b100
  } relay_state_type;
endpackage : latch_ack_pkg

/* File: rtl/relay_off_delay.sv */
// relay_off_delay: one relay latch with acknowledge and switch-off delay
// assumes source and acknowledge are synchronous to clk_i
`timescale 1ns/1ps
module relay_off_delay (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // relay control
  input wire logic src_i,     // source that sets the latch
  input wire logic ack_i,     // accepted acknowledge request
  input wire logic latch_en_i, // latching configured for this relay
  // output
  output logic relay_o        // relay drive
);
  latch_ack_pkg::relay_state_type state_reg, state_next; // release state
  logic [latch_ack_pkg::TMR_W-1:0] tmr_reg, tmr_next; // off-delay count
  logic relay_reg, relay_next; // relay drive
  // next state computation
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    unique case (state_reg)
      latch_ack_pkg::RLY_IDLE: begin
        // source active raises the latch
        if (src_i && latch_en_i) begin
          state_next = latch_ack_pkg::RLY_HELD;
        end
      end
      latch_ack_pkg::RLY_HELD: begin
        // ack refused while source active
        if (ack_i && !src_i) begin
          state_next = latch_ack_pkg::RLY_WAIT;
          tmr_next = latch_ack_pkg::TMR_W'(latch_ack_pkg::OFF_DELAY_CYC);
        end
      end
      latch_ack_pkg::RLY_WAIT: begin
        // source returns: hold again
        if (src_i) begin
          state_next = latch_ack_pkg::RLY_HELD;
          tmr_next = latch_ack_pkg::TMR_ZERO;
        end else if (tmr_reg == latch_ack_pkg::TMR_ONE) begin
          state_next = latch_ack_pkg::RLY_IDLE;
          tmr_next = latch_ack_pkg::TMR_ZERO;
        end else begin
          tmr_next = tmr_reg - latch_ack_pkg::TMR_ONE;
        end
      end
    endcase
    // drive while source active or latch not yet released
    relay_next = src_i || (state_next != latch_ack_pkg::RLY_IDLE);
  end
  // registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= latch_ack_pkg::RLY_IDLE;
      tmr_reg <= latch_ack_pkg::TMR_ZERO;
      relay_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      relay_reg <= relay_next;
    end
  end
  assign relay_o = relay_reg;
endmodule : relay_off_delay

/* File: rtl/latch_acknowledge_logic.sv */
// latch_acknowledge_logic: latches lamps, relays, telecontrol signals and trip commands
// and clears them by individual, group, link or alarm-driven acknowledge
// each relay output passes through its own relay_off_delay instance
// link requests count as remote and are refused while remote is off
// assumes all inputs are synchronous to clk_i; configuration is static
`timescale 1ns/1ps
//
// Operation
// - own lamp acknowledge clears that lamp only
// - remote disabled ignores all group acknowledges
// - remote disabled rejects link acknowledge requests
// - group relay acknowledge clears all relays
// - alarm clears lamps configured auto-clear
// - auto-clear configured per lamp separately
// - no clear while latch source active
// - relay releases after off delay elapses
// - alarm acknowledge applies to lamps only
module latch_acknowledge_logic (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // configuration, static levels
  // remote enable gates group and link paths only, not own acknowledges
  input wire logic remote_ack_en_i,
  input wire logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_latch_en_i,
  input wire logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_auto_clear_i,
  input wire logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_latch_en_i,
  // lamp sources and acknowledges
  input wire logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_src_i,
  input wire logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_clear_source_i,
  input wire logic group_lamp_clear_source_i,
  // alarms
  // a rising edge of either is one new alarm
  input wire logic prot_alarm_i,
  input wire logic general_alarm_i,
  // relays
  // relay latching and release sit in relay_off_delay
  input wire logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_src_i,
  input wire logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_clear_source_i,
  input wire logic group_relay_clear_source_i,
  // telecontrol signals
  input wire logic [latch_ack_pkg::NUM_SCADA-1:0] scada_src_i,
  input wire logic group_scada_clear_source_i,
  // link requests: levels, one clear per high cycle
  input wire logic link_ack_lamps_i,
  input wire logic link_ack_relays_i,
  input wire logic link_ack_scada_i,
  input wire logic link_ack_trips_i,
  // trip commands
  // one latch per switchgear instance
  input wire logic [latch_ack_pkg::NUM_SWGR-1:0] trip_src_i,
  input wire logic [latch_ack_pkg::NUM_SWGR-1:0] trip_clear_source_i,
  // outputs
  output logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_o,
  output logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_o,
  output logic [latch_ack_pkg::NUM_SCADA-1:0] scada_o,
  output logic [latch_ack_pkg::NUM_SWGR-1:0] trip_o,
  output logic link_ack_rejected_o
);
  // latched states: a latch remembers an event after its source has gone
  // the drive of each output is its source or its latch
  logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_latch_reg, lamp_latch_next;
  logic [latch_ack_pkg::NUM_SCADA-1:0] scada_latch_reg, scada_latch_next;
  logic [latch_ack_pkg::NUM_SWGR-1:0] trip_latch_reg, trip_latch_next;
  logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_out_reg, lamp_out_next; // lamp drive
  logic [latch_ack_pkg::NUM_SCADA-1:0] scada_out_reg, scada_out_next; // signal drive
  logic [latch_ack_pkg::NUM_SWGR-1:0] trip_out_reg, trip_out_next; // trip drive
  logic rej_reg, rej_next; // link acknowledge refused flag
  // edge detect history: last cycle's level of each own and group acknowledge and each alarm input
  // reset low, the idle level of the inputs, so no false edge follows reset
  logic prot_alarm_reg; // protection alarm
  logic general_alarm_reg; // general alarm
  logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_ack_d_reg; // own lamp acknowledges
  logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_ack_d_reg; // own relay acknowledges
  logic [latch_ack_pkg::NUM_SWGR-1:0] trip_ack_d_reg; // own trip acknowledges
  logic grp_lamp_d_reg; // group lamp acknowledge
  logic grp_relay_d_reg; // group relay acknowledge
  logic grp_scada_d_reg; // group telecontrol acknowledge
  // derived strobes, high one cycle per accepted request
  logic alarm_rise; // new alarm from either input
  logic grp_lamp_ack; // accepted group lamp clear
  logic grp_relay_ack; // accepted group relay clear
  logic grp_scada_ack; // accepted group telecontrol clear
  logic grp_trip_ack; // accepted link trip clear
  logic [latch_ack_pkg::NUM_LAMPS-1:0] lamp_ack; // per-lamp clear request
  logic [latch_ack_pkg::NUM_RELAYS-1:0] relay_ack; // per-relay clear request
  logic [latch_ack_pkg::NUM_SWGR-1:0] trip_ack; // per-instance trip clear request

  // rising edge of a level: an acknowledge acts when the signal becomes active
  // a held-high acknowledge therefore acts once only
  function automatic logic rise(input logic now, input logic was);
    rise = now && !was;
  endfunction : rise

  // new latch value: set by source, cleared only with source gone
  // set beats clear, so an acknowledge while the source stands is lost
  function automatic logic latch_upd(input logic cur, input logic src, input logic en,
                                     input logic clr);
    latch_upd = (src && en) || (cur && !(clr && !src));
  endfunction : latch_upd

  // acknowledge strobes
  always_comb begin
    // new alarm from any protection function or general alarm
    alarm_rise = rise(prot_alarm_i, prot_alarm_reg) || rise(general_alarm_i, general_alarm_reg);
    // external group paths gated by remote enable
    // link requests are levels and act on every cycle that they stand
    grp_lamp_ack = remote_ack_en_i &&
                   (rise(group_lamp_clear_source_i, grp_lamp_d_reg) || link_ack_lamps_i);
    grp_relay_ack = remote_ack_en_i &&
                    (rise(group_relay_clear_source_i, grp_relay_d_reg) || link_ack_relays_i);
    grp_scada_ack = remote_ack_en_i &&
                    (rise(group_scada_clear_source_i, grp_scada_d_reg) || link_ack_scada_i);
    // the link request is the only group path for trip commands
    grp_trip_ack = remote_ack_en_i && link_ack_trips_i;
    // individual lamp clears, own source or auto-clear on alarm
    // auto-clear acts only on lamps whose own setting is on
    for (int i = 0; i < latch_ack_pkg::NUM_LAMPS; i++) begin
      lamp_ack[i] = rise(lamp_clear_source_i[i], lamp_ack_d_reg[i]) || grp_lamp_ack ||
                    (alarm_rise && lamp_auto_clear_i[i]);
    end
    // relay clears: own input or group; alarm never reaches relays
    // alarm_rise is left out here on purpose
    for (int i = 0; i < latch_ack_pkg::NUM_RELAYS; i++) begin
      relay_ack[i] = rise(relay_clear_source_i[i], relay_ack_d_reg[i]) || grp_relay_ack;
    end
    // trip clears per switchgear instance
    // own acknowledges need no remote enable
    for (int i = 0; i < latch_ack_pkg::NUM_SWGR; i++) begin
      trip_ack[i] = rise(trip_clear_source_i[i], trip_ack_d_reg[i]) || grp_trip_ack;
    end
  end

  // next latch and output values
  always_comb begin
    // defaults: every latch holds
    lamp_latch_next = lamp_latch_reg;
    scada_latch_next = scada_latch_reg;
    trip_latch_next = trip_latch_reg;
    // lamps: own, group or alarm clear, latching per lamp enable
    for (int i = 0; i < latch_ack_pkg::NUM_LAMPS; i++) begin
      lamp_latch_next[i] = latch_upd(lamp_latch_reg[i], lamp_src_i[i], lamp_latch_en_i[i], lamp_ack[i]);
    end
    // telecontrol signals: group or link clear, always latching
    for (int i = 0; i < latch_ack_pkg::NUM_SCADA; i++) begin
      scada_latch_next[i] = latch_upd(scada_latch_reg[i], scada_src_i[i], 1'b1, grp_scada_ack);
    end
    // trip commands: own or link clear, always latching
    for (int i = 0; i < latch_ack_pkg::NUM_SWGR; i++) begin
      trip_latch_next[i] = latch_upd(trip_latch_reg[i], trip_src_i[i], 1'b1, trip_ack[i]);
    end
    // outputs follow source or latch
    // the next latch value keeps each output one register from its inputs
    lamp_out_next = lamp_src_i | lamp_latch_next;
    scada_out_next = scada_src_i | scada_latch_next;
    trip_out_next = trip_src_i | trip_latch_next;
    // refused link request with remote acknowledge off
    // the flag stands one cycle for each refused request cycle
    rej_next = !remote_ack_en_i &&
               (link_ack_lamps_i || link_ack_relays_i || link_ack_scada_i || link_ack_trips_i);
  end

  // state registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // reset: latches, drives and history all idle low
      lamp_latch_reg <= '0;
      scada_latch_reg <= '0;
      trip_latch_reg <= '0;
      lamp_out_reg <= '0;
      scada_out_reg <= '0;
      trip_out_reg <= '0;
      rej_reg <= 1'b0;
      // edge history
      prot_alarm_reg <= 1'b0;
      general_alarm_reg <= 1'b0;
      lamp_ack_d_reg <= '0;
      relay_ack_d_reg <= '0;
      trip_ack_d_reg <= '0;
      grp_lamp_d_reg <= 1'b0;
      grp_relay_d_reg <= 1'b0;
      grp_scada_d_reg <= 1'b0;
    end else begin
      // run: register every next value
      lamp_latch_reg <= lamp_latch_next;
      scada_latch_reg <= scada_latch_next;
      trip_latch_reg <= trip_latch_next;
      lamp_out_reg <= lamp_out_next;
      scada_out_reg <= scada_out_next;
      trip_out_reg <= trip_out_next;
      rej_reg <= rej_next;
      // history: this cycle's levels, for edge detection next cycle
      prot_alarm_reg <= prot_alarm_i;
      general_alarm_reg <= general_alarm_i;
      lamp_ack_d_reg <= lamp_clear_source_i;
      relay_ack_d_reg <= relay_clear_source_i;
      trip_ack_d_reg <= trip_clear_source_i;
      grp_lamp_d_reg <= group_lamp_clear_source_i;
      grp_relay_d_reg <= group_relay_clear_source_i;
      grp_scada_d_reg <= group_scada_clear_source_i;
    end
  end

  // one latch and off-delay per relay
  // the timer is per relay, so each output releases on its own schedule
  for (genvar g = 0; g < latch_ack_pkg::NUM_RELAYS; g++) begin : g_relay
    relay_off_delay u_relay (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .src_i(relay_src_i[g]),
      .ack_i(relay_ack[g]),
      .latch_en_i(relay_latch_en_i[g]),
      .relay_o(relay_o[g])
    );
  end

  // every output comes straight from a flip-flop
  assign lamp_o = lamp_out_reg;
  assign scada_o = scada_out_reg;
  assign trip_o = trip_out_reg;
  assign link_ack_rejected_o = rej_reg;
endmodule : latch_acknowledge_logic

/* File: verif/latch_ack_chk.sv */
// latch_ack_chk: port timing checks for the latch acknowledge logic
// assumes the bind below attaches it to every latch_acknowledge_logic
`timescale 1ns/1ps
module latch_ack_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched inputs
  input wire logic remote_ack_en_i,
  input wire logic [7:0] relay_latch_en_i,
  input wire logic [7:0] lamp_src_i,
  input wire logic prot_alarm_i,
  input wire logic [7:0] relay_src_i,
  input wire logic [7:0] relay_clear_source_i,
  input wire logic [7:0] scada_src_i,
  input wire logic group_scada_clear_source_i,
  input wire logic link_ack_lamps_i,
  input wire logic link_ack_relays_i,
  input wire logic link_ack_scada_i,
  input wire logic link_ack_trips_i,
  // watched outputs
  input wire logic [7:0] lamp_o,
  input wire logic [7:0] relay_o,
  input wire logic [7:0] scada_o,
  input wire logic link_ack_rejected_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic lnk; // any link request
  logic rq; // relay 0 latched, source low
  assign lnk = link_ack_lamps_i | link_ack_relays_i | link_ack_scada_i | link_ack_trips_i;
  assign rq = relay_latch_en_i[0] & relay_o[0] & ~relay_src_i[0];
  logic ack0_d_reg; // relay 0 own acknowledge, last cycle
  logic [10:0] rel_cnt_reg, rel_cnt_next; // cycles since relay 0 release began, 0 idle
  // release timer: counts from an accepted relay 0 acknowledge, too long for a delay range
  always_comb begin
    rel_cnt_next = rel_cnt_reg;
    if (relay_src_i[0]) begin
      // a returning source holds the relay again, so the count returns to idle until a new acknowledge edge
      rel_cnt_next = 11'h000;
    end else if (rel_cnt_reg == 11'h000) begin
      // start on a new acknowledge edge while the relay is latched
      if (relay_clear_source_i[0] && !ack0_d_reg && rq) begin
        rel_cnt_next = 11'h001;
      end
    end else if (rel_cnt_reg == 11'h3E9) begin
      // release seen, back to idle
      rel_cnt_next = 11'h000;
    end else begin
      rel_cnt_next = rel_cnt_reg + 11'h001;
    end
  end
  // helper registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack0_d_reg <= 1'b0;
      rel_cnt_reg <= 11'h000;
    end else begin
      ack0_d_reg <= relay_clear_source_i[0];
      rel_cnt_reg <= rel_cnt_next;
    end
  end
  a_lamp_src_wins: assert property (lamp_src_i != 0 |=> (lamp_o & $past(lamp_src_i)) == $past(lamp_src_i))
    else $error("lamp low with source high");
  a_relay_src_wins: assert property (relay_src_i != 0 |=> (relay_o & $past(relay_src_i)) == $past(relay_src_i))
    else $error("relay low with source high");
  a_scada_src_wins: assert property (scada_src_i != 0 |=> (scada_o & $past(scada_src_i)) == $past(scada_src_i))
    else $error("scada low with source high");
  a_link_reject: assert property (lnk && !remote_ack_en_i |=> link_ack_rejected_o)
    else $error("link request not rejected");
  a_link_accept: assert property (remote_ack_en_i |=> !link_ack_rejected_o)
    else $error("link request rejected while enabled");
  a_relay_hold: assert property ($rose(relay_clear_source_i[0]) && rq |=> relay_o[0] [*8])
    else $error("relay released before delay");
  a_relay_release: assert property (rel_cnt_reg == 11'h3E8 && !relay_src_i[0] |=> !relay_o[0])
    else $error("relay not released after delay");
  a_relay_timer_hold: assert property (rel_cnt_reg != 11'h000 && rel_cnt_reg != 11'h3E9 |-> relay_o[0])
    else $error("relay released during delay");
  a_alarm_scada: assert property ((scada_src_i == 0 && !group_scada_clear_source_i && !link_ack_scada_i) [*3]
    ##0 $rose(prot_alarm_i) |=> $stable(scada_o))
    else $error("alarm changed scada");
  c_reject: cover property ($rose(link_ack_rejected_o));
  c_relay_off: cover property ($fell(relay_o[0]));
  c_lamp_off: cover property ($fell(lamp_o[0]));
endmodule : latch_ack_chk
bind latch_acknowledge_logic latch_ack_chk u_latch_ack_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .remote_ack_en_i(remote_ack_en_i), .relay_latch_en_i(relay_latch_en_i), .lamp_src_i(lamp_src_i),
  .prot_alarm_i(prot_alarm_i), .relay_src_i(relay_src_i), .relay_clear_source_i(relay_clear_source_i),
  .scada_src_i(scada_src_i), .group_scada_clear_source_i(group_scada_clear_source_i),
  .link_ack_lamps_i(link_ack_lamps_i), .link_ack_relays_i(link_ack_relays_i),
  .link_ack_scada_i(link_ack_scada_i), .link_ack_trips_i(link_ack_trips_i), .lamp_o(lamp_o),
  .relay_o(relay_o), .scada_o(scada_o), .link_ack_rejected_o(link_ack_rejected_o));

/* File: verif/latch_acknowledge_logic_tb.sv */
// latch_acknowledge_logic_tb: self-checking bench for the latch acknowledge logic
// assumes the checker binds itself; outputs settle within 3 cycles except relays
`timescale 1ns/1ps
module latch_acknowledge_logic_tb;
  logic clk_i, sys_rst_i, ren, glc, grc, gsc, pa, ga, kl, kr, ks, kt, rej, xr;
  logic [7:0] lle, lac, rle, ls, lcs, rs, rcs, ss, lamp, rly, scd, el, er, es;
  logic [1:0] ts, tcs, trp, et;
  logic [26:0] q[$]; // expected outputs, oldest first
  int err_count, checks;
  event go; // a new note is waiting
  latch_acknowledge_logic u_latch_acknowledge_logic (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .remote_ack_en_i(ren), .lamp_latch_en_i(lle), .lamp_auto_clear_i(lac), .relay_latch_en_i(rle),
    .lamp_src_i(ls), .lamp_clear_source_i(lcs), .group_lamp_clear_source_i(glc),
    .prot_alarm_i(pa), .general_alarm_i(ga), .relay_src_i(rs), .relay_clear_source_i(rcs),
    .group_relay_clear_source_i(grc), .scada_src_i(ss), .group_scada_clear_source_i(gsc),
    .link_ack_lamps_i(kl), .link_ack_relays_i(kr), .link_ack_scada_i(ks), .link_ack_trips_i(kt),
    .trip_src_i(ts), .trip_clear_source_i(tcs), .lamp_o(lamp), .relay_o(rly), .scada_o(scd),
    .trip_o(trp), .link_ack_rejected_o(rej));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // wait n rising edges
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  // note expected outputs once settled
  task automatic note();
    step(3);
    q.push_back({xr, et, es, er, el});
    -> go;
  endtask : note
  // compare seen against expected
  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected outputs: expected %h seen %h", exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // monitor: oldest note against the outputs
  initial forever begin
    @go;
    #1 check({rej, trp, scd, rly, lamp}, q.pop_front());
  end
  // watchdog
  initial begin
    step(20000);
    err_count++;
    results();
  end
  // main sequence
  initial begin
    logic [7:0] m;
    int t;
    {ren, glc, grc, gsc, pa, ga, kl, kr, ks, kt, xr} = '0;
    {lac, ls, lcs, rs, rcs, ss, ts, tcs, el, er, es, et} = '0;
    lle = 8'hFF;
    rle = 8'hFF;
    sys_rst_i = 1'b1;
    err_count = 0;
    checks = 0;
    m = 8'($urandom(32'h06BB7468));
    ren = 1'b1;
    step(2);
    sys_rst_i <= 1'b0;
    // own lamp acknowledge, refused while source high
    m = 8'($urandom()) | 8'h01;
    ls <= m;
    el = m;
    note();
    lcs <= 8'h01;
    note();
    ls <= 8'h00;
    lcs <= 8'h00;
    note();
    lcs <= 8'h01;
    el = m & 8'hFE;
    note();
    lcs <= 8'h00;
    $display("test 1 done");
    // alarms clear only auto-clear lamps
    for (int i = 0; i < 2; i++) begin
      m = 8'($urandom());
      lac <= m;
      {ls, ss, rs} <= '1;
      ts <= 2'b11;
      step(1);
      {ls, ss, rs, ts} <= '0;
      step(3);
      if (i == 0) pa <= 1'b1;
      else ga <= 1'b1;
      {el, es, er, et} = {~m, 8'hFF, 8'hFF, 2'b11};
      note();
      {pa, ga} <= 2'b00;
    end
    $display("test 2 done");
    // remote disabled: groups and link ignored
    ren <= 1'b0;
    {glc, grc, gsc} <= 3'b111;
    note();
    {glc, grc, gsc} <= 3'b000;
    xr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {kl, kr, ks, kt} <= 4'b1000 >> i;
      note();
    end
    {kl, kr, ks, kt} <= 4'h0;
    xr = 1'b0;
    note();
    // remote enabled: groups clear, relays after delay
    ren <= 1'b1;
    step(1);
    {glc, grc, gsc, kt} <= 4'hF;
    {el, es, et} = '0;
    note();
    {glc, grc, gsc, kt} <= 4'h0;
    step(500);
    note();
    step(500);
    er = 8'h00;
    note();
    $display("test 3 done");
    // per-instance relay and trip acknowledge
    rs <= 8'hFF;
    ts <= 2'b11;
    step(1);
    {rs, ts} <= '0;
    step(3);
    t = $urandom() % 2;
    rcs <= 8'h01;
    tcs <= 2'(1 << t);
    {er, et} = {8'hFF, ~2'(1 << t)};
    note();
    {rcs, tcs} <= '0;
    step(1005);
    er = 8'hFE;
    note();
    // link requests with remote enabled clear lamps, signals and relays
    {ls, ss} <= 16'hFFFF;
    step(1);
    {ls, ss} <= 16'h0000;
    step(3);
    {kl, kr, ks} <= 3'h7;
    {el, es} = 16'h0000;
    note();
    {kl, kr, ks} <= 3'h0;
    step(1000);
    er = 8'h00;
    note();
    $display("test 4 done");
    results();
  end
endmodule : latch_acknowledge_logic_tb
